// >>> rtl/rwpp_pkg.sv
// Package: register map, field positions, reset values of the protect block
package rwpp_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PROTECT   = 8'h00;
    localparam logic [7:0] OFF_PROC_MODE = 8'h04;
    localparam logic [7:0] OFF_CLK_CTRL  = 8'h08;
    localparam logic [7:0] OFF_CLK_DIV   = 8'h0c;
    localparam logic [7:0] OFF_PORT_DATA = 8'h10;
    localparam logic [7:0] OFF_PORT_DIR  = 8'h14;
    localparam logic [7:0] OFF_FUNC_SEL  = 8'h18;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h1c;

    // ----------------------------------------------------------------
    // Protect control fields
    // ----------------------------------------------------------------
    localparam int PRC_CLK_BIT  = 0;  // Clock control and divider
    localparam int PRC_MODE_BIT = 1;  // Processor mode
    localparam int PRC_DIR_BIT  = 2;  // Port direction, one write only
    localparam int PRC_WIDTH    = 3;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int PORT_PINS = 8;
    localparam int SEL_W     = 2;
    localparam logic [PRC_WIDTH-1:0] RST_PROTECT   = 3'h0;
    localparam logic [15:0]          RST_PROC_MODE = 16'h0000;
    localparam logic [15:0]          RST_CLK_CTRL  = 16'h0000;
    localparam logic [7:0]           RST_CLK_DIV   = 8'h00;
    localparam logic [7:0]           RST_PORT_DATA = 8'h00;
    localparam logic [7:0]           RST_PORT_DIR  = 8'h00;
    localparam logic [15:0]          RST_FUNC_SEL  = 16'h0000;

    // Output function choice per pin
    typedef enum logic [1:0] {
        RWPP_FN_PORT = 2'h0,
        RWPP_FN_PERA = 2'h1,
        RWPP_FN_PERB = 2'h2,
        RWPP_FN_PERC = 2'h3
    } rwpp_fn_t;
endpackage

// >>> rtl/rwpp_pin_cell.sv
// One port pin: output function select and direction gating
`timescale 1ns/100ps
`default_nettype none
module rwpp_pin_cell (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       latch_bit,
    input  wire logic       dir_bit,
    input  wire logic [1:0] sel,
    input  wire logic       per_a,
    input  wire logic       per_b,
    input  wire logic       per_c,
    output var  logic       pin_out_q,
    output var  logic       pin_oe_q
);
    logic out_d;

    // Select the output source of the pin
    always_comb begin
        case (rwpp_pkg::rwpp_fn_t'(sel))
            rwpp_pkg::RWPP_FN_PERA: out_d = per_a;
            rwpp_pkg::RWPP_FN_PERB: out_d = per_b;
            rwpp_pkg::RWPP_FN_PERC: out_d = per_c;
            default:                out_d = latch_bit;
        endcase
    end

    // Drive only while direction selects output
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            pin_out_q <= dir_bit ? out_d : 1'b0;
            pin_oe_q  <= dir_bit;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/rwpp_top.sv
// Protected system registers, one-shot direction unlock and port output
//
// Behaviour
// - Mode and clock registers are writable only while unlocked, and software relocks them.
// - The port direction register accepts a write only while protect bit 2 is 1.
// - Protect bit 2 clears itself on the next completed write to a mapped address other than the protect register after the one that set it.
// - A pin drives its data latch value only while its direction bit selects output.
// - Each pin's function select field routes port data or one peripheral output to it.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rwpp_top (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic [7:0]  PORT_IN,
    input  wire logic [7:0]  PER_A_OUT,
    input  wire logic [7:0]  PER_B_OUT,
    input  wire logic [7:0]  PER_C_OUT,
    output var  logic [7:0]  PORT_OUT,
    output var  logic [7:0]  PORT_OE
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [rwpp_pkg::PRC_WIDTH-1:0] protect_q;
    logic [15:0] proc_mode_q;
    logic [15:0] clk_ctrl_q;
    logic [7:0]  clk_div_q;
    logic [7:0]  port_data_q;
    logic [7:0]  port_dir_q;
    logic [15:0] func_sel_q;
    logic [7:0]  pin_meta_q;
    logic [7:0]  pin_sync_q;
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rdata_d;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state; write commits where PREADY is seen high
    assign access = PSEL && PENABLE;
    assign wr_en  = access && PREADY && PWRITE;

    // Address decode and read mux
    always_comb begin
        mapped  = 1'b1;
        rdata_d = 32'h0000_0000;
        case (PADDR)
            rwpp_pkg::OFF_PROTECT:   rdata_d = {29'h0, protect_q};
            rwpp_pkg::OFF_PROC_MODE: rdata_d = {16'h0, proc_mode_q};
            rwpp_pkg::OFF_CLK_CTRL:  rdata_d = {16'h0, clk_ctrl_q};
            rwpp_pkg::OFF_CLK_DIV:   rdata_d = {24'h0, clk_div_q};
            rwpp_pkg::OFF_PORT_DATA: rdata_d = {24'h0, port_data_q};
            rwpp_pkg::OFF_PORT_DIR:  rdata_d = {24'h0, port_dir_q};
            rwpp_pkg::OFF_FUNC_SEL:  rdata_d = {16'h0, func_sel_q};
            rwpp_pkg::OFF_PIN_LEVEL: rdata_d = {24'h0, pin_sync_q};
            default:                 mapped  = 1'b0;
        endcase
    end

    // Ready, read data and error response
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= access && !PREADY;
            PRDATA  <= (access && !PREADY && !PWRITE) ? rdata_d : 32'h0000_0000;
            PSLVERR <= access && !PREADY && !mapped;
        end
    end

    // ----------------------------------------------------------------
    // Protect control
    // ----------------------------------------------------------------
    // Direction unlock dies on any other completed write to a mapped address
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            protect_q <= rwpp_pkg::RST_PROTECT;
        end else if (wr_en && PADDR == rwpp_pkg::OFF_PROTECT) begin
            protect_q <= PWDATA[rwpp_pkg::PRC_WIDTH-1:0];
        end else if (wr_en && mapped) begin
            protect_q[rwpp_pkg::PRC_DIR_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Protected system registers
    // ----------------------------------------------------------------
    // Mode register guarded by its own protect bit
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            proc_mode_q <= rwpp_pkg::RST_PROC_MODE;
        end else if (wr_en && PADDR == rwpp_pkg::OFF_PROC_MODE
                     && protect_q[rwpp_pkg::PRC_MODE_BIT]) begin
            proc_mode_q <= PWDATA[15:0];
        end
    end

    // Clock control and divider share one protect bit
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            clk_ctrl_q <= rwpp_pkg::RST_CLK_CTRL;
            clk_div_q  <= rwpp_pkg::RST_CLK_DIV;
        end else if (wr_en && protect_q[rwpp_pkg::PRC_CLK_BIT]) begin
            if (PADDR == rwpp_pkg::OFF_CLK_CTRL) begin
                clk_ctrl_q <= PWDATA[15:0];
            end
            if (PADDR == rwpp_pkg::OFF_CLK_DIV) begin
                clk_div_q <= PWDATA[7:0];
            end
        end
    end

    // Direction register, one write per unlock
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            port_dir_q <= rwpp_pkg::RST_PORT_DIR;
        end else if (wr_en && PADDR == rwpp_pkg::OFF_PORT_DIR
                     && protect_q[rwpp_pkg::PRC_DIR_BIT]) begin
            port_dir_q <= PWDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Unprotected port registers and pin sampling
    // ----------------------------------------------------------------
    // Data latch and function select
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            port_data_q <= rwpp_pkg::RST_PORT_DATA;
            func_sel_q  <= rwpp_pkg::RST_FUNC_SEL;
        end else if (wr_en) begin
            if (PADDR == rwpp_pkg::OFF_PORT_DATA) begin
                port_data_q <= PWDATA[7:0];
            end
            if (PADDR == rwpp_pkg::OFF_FUNC_SEL) begin
                func_sel_q <= PWDATA[15:0];
            end
        end
    end

    // Two-stage synchroniser for the pin levels
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= PORT_IN;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Pin output cells
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < rwpp_pkg::PORT_PINS; g++) begin : g_pin
            rwpp_pin_cell u_cell (
                .clk       (CLK),
                .resetn    (RESETN),
                .latch_bit (port_data_q[g]),
                .dir_bit   (port_dir_q[g]),
                .sel       (func_sel_q[g*2 +: 2]),
                .per_a     (PER_A_OUT[g]),
                .per_b     (PER_B_OUT[g]),
                .per_c     (PER_C_OUT[g]),
                .pin_out_q (PORT_OUT[g]),
                .pin_oe_q  (PORT_OE[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    clk_locked_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_en && PADDR == rwpp_pkg::OFF_CLK_CTRL && !protect_q[0] |=> $stable(clk_ctrl_q))
        else $error("clock control changed while protected");

    clk_open_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_en && PADDR == rwpp_pkg::OFF_CLK_DIV && protect_q[0]
        |=> clk_div_q == $past(PWDATA[7:0]))
        else $error("divider write lost while unprotected");

    mode_locked_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_en && PADDR == rwpp_pkg::OFF_PROC_MODE && !protect_q[1] |=> $stable(proc_mode_q))
        else $error("mode register changed while protected");

    dir_locked_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !protect_q[2] |=> $stable(port_dir_q))
        else $error("direction changed without unlock");

    unlock_once_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_en && mapped && PADDR != rwpp_pkg::OFF_PROTECT |=> !protect_q[2])
        else $error("direction unlock survived a write");

    pin_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !port_dir_q[0] ##1 !port_dir_q[0] |=> !PORT_OE[0] && !PORT_OUT[0])
        else $error("pin driven while set as input");

    pin_port_a: assert property (@(posedge CLK) disable iff (!RESETN)
        port_dir_q[2] && func_sel_q[5:4] == 2'h0 |=> PORT_OUT[2] == $past(port_data_q[2]))
        else $error("port function not routed to pin");

    pin_per_a: assert property (@(posedge CLK) disable iff (!RESETN)
        port_dir_q[2] && func_sel_q[5:4] == 2'h2 |=> PORT_OUT[2] == $past(PER_B_OUT[2]))
        else $error("peripheral output not routed to pin");

    ready_pulse_a: assert property (@(posedge CLK) disable iff (!RESETN)
        access && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after one wait");

    unmapped_err_a: assert property (@(posedge CLK) disable iff (!RESETN)
        access && !PREADY && !mapped |=> PSLVERR && PREADY)
        else $error("unmapped address not flagged");
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the protected register and port block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port_in;
    logic [7:0]  per_a;
    logic [7:0]  per_b;
    logic [7:0]  per_c;
    logic [7:0]  port_out;
    logic [7:0]  port_oe;
    int          n_errors;
    int          total_checks;

    rwpp_top u_rwpp_top (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PORT_IN(port_in), .PER_A_OUT(per_a), .PER_B_OUT(per_b),
        .PER_C_OUT(per_c), .PORT_OUT(port_out), .PORT_OE(port_oe)
    );

    // ----------------------------------------------------------------
    // Clock, comparison and closing
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // APB master: setup, access until ready, release, one idle edge
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 7; i++) rdchk(8'(i * 4), 32'h0);
        check({24'h0, port_oe}, 32'h0);
    endtask

    task automatic t_protect;
        wr(8'h04, 32'h0183);
        wr(8'h08, 32'h2008);
        wr(8'h0c, 32'h12);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        rdchk(8'h0c, 32'h0);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h0183);
        wr(8'h08, 32'h2008);
        wr(8'h0c, 32'h12);
        rdchk(8'h04, 32'h0183);
        rdchk(8'h08, 32'h2008);
        rdchk(8'h0c, 32'h12);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h1111);
        wr(8'h08, 32'h1111);
        rdchk(8'h04, 32'h0183);
        rdchk(8'h08, 32'h1111);
        wr(8'h00, 32'h0);
        wr(8'h0c, 32'hff);
        rdchk(8'h0c, 32'h12);
    endtask

    task automatic t_dir;
        wr(8'h10, 32'ha5);
        wr(8'h14, 32'hff);
        rdchk(8'h14, 32'h0);
        wr(8'h00, 32'h4);
        rdchk(8'h00, 32'h4);
        wr(8'h14, 32'h3c);
        rdchk(8'h14, 32'h3c);
        rdchk(8'h00, 32'h0);
        wr(8'h14, 32'hff);
        rdchk(8'h14, 32'h3c);
        wr(8'h00, 32'h4);
        wr(8'h10, 32'ha5);
        wr(8'h14, 32'hff);
        rdchk(8'h14, 32'h3c);
    endtask

    task automatic t_pins;
        logic [7:0] src;
        for (int f = 0; f < 4; f++) begin
            wr(8'h18, {16'h0, {8{2'(f)}}});
            repeat (2) @(posedge clk);
            src = (f == 0) ? 8'ha5 : (f == 1) ? per_a : (f == 2) ? per_b : per_c;
            check({24'h0, port_out}, {24'h0, src & 8'h3c});
            check({24'h0, port_oe}, 32'h3c);
        end
        rdchk(8'h1c, 32'h69);
    endtask

    task automatic t_unmapped;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'h20, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        apb(1'b1, 8'h24, 32'hffff, r, e);
        check({31'h0, e}, 32'h1);
        rdchk(8'h10, 32'ha5);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        n_errors = 0;
        total_checks = 0;
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        port_in = 8'h69;
        per_a = 8'h5a;
        per_b = 8'hc3;
        per_c = 8'h96;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // No DMA bank registers, interrupts or bank switching here
        t_reset();
        t_protect();
        t_dir();
        t_pins();
        t_unmapped();
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
